// *** logic/video_sync_cfg.svh ***
`ifndef VIDEO_SYNC_CFG_SVH
`define VIDEO_SYNC_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_VIDEO_STATUS 8'h00
`define OFS_OPCODE 8'h04
`define OFS_HSYNC_STOP 8'h08
`define OFS_HFIELD_START 8'h0c
`define OFS_HFIELD_STOP 8'h10
`define OFS_LINE_LEN 8'h14
`define OFS_VSYNC_STOP 8'h18
`define OFS_VFIELD_START 8'h1c
`define OFS_VFIELD_STOP 8'h20
`define OFS_FRAME_LEN 8'h24
`define OFS_DEFAULT_VIDEO 8'h28
`define OFS_POSITION 8'h2c
`define OFS_CONTROL 8'h30

// ==========================================================
// Field positions
`define BIT_DISPLAY_ON 0
`define BIT_ACTIVE 1
`define BIT_PENDING 2
`define BIT_REFRESH 3
`define BIT_SLAVE 0
`define BIT_BLANK_INPUT 1
`define BIT_WINDOW_ENABLE 2
`define OPCODE_LSB 8
`define OPCODE_MSB 15
`define POS_V_LSB 16

// ==========================================================
// Encodings and reset values
`define CMD_LOAD_REGISTER 8'h01
`define CMD_LOAD_ALL 8'h02
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESET_TIMING 12'h000
`define RESET_DEFAULT_VIDEO 8'h00
`define VIDEO_CLOCK_MAX_MHZ 25

`endif

// *** logic/video_sync_pkg.sv ***
package video_sync_pkg;

	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_type;
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_type;

	typedef struct packed {
		logic [11:0] hsync_stop;
		logic [11:0] horizontal_field_start;
		logic [11:0] horizontal_field_stop;
		logic [11:0] line_len;
		logic [11:0] vsync_stop;
		logic [11:0] vertical_field_start;
		logic [11:0] vertical_field_stop;
		logic [11:0] frame_len;
	} timing_type;

	typedef struct packed {
		logic hsync;
		logic vsync;
		logic blank;
	} sync_in_type;

	typedef struct packed {
		logic hsync;
		logic hsync_oe_n;
		logic vsync;
		logic vsync_oe_n;
		logic blank;
		logic blank_oe_n;
	} sync_out_type;

endpackage : video_sync_pkg

// *** logic/pixel_fifo.sv ***
`timescale 1ns/1ps

module pixel_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Fill side
	input wire logic s_valid,
	input wire logic [WIDTH-1:0] s_data,
	output logic s_ready,
	// Drain side
	output logic m_valid,
	output logic [WIDTH-1:0] m_data,
	input wire logic m_ready
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} fifo_state_type;

	fifo_state_type st;
	fifo_state_type next_st;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] ptr);
		return (ptr == AW'(DEPTH - 1)) ? '0 : AW'(ptr + 1'b1);
	endfunction : bump

	assign s_ready = st.count != CW'(DEPTH);
	assign m_valid = st.count != '0;
	assign m_data = st.mem[st.rd_ptr];
	assign push = s_valid & s_ready;
	assign pop = m_valid & m_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr_ptr] = s_data;
			next_st.wr_ptr = bump(st.wr_ptr);
		end
		if (pop) begin
			next_st.rd_ptr = bump(st.rd_ptr);
		end
		if (push && !pop) begin
			next_st.count = CW'(st.count + 1'b1);
		end else if (pop && !push) begin
			next_st.count = CW'(st.count - 1'b1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule : pixel_fifo

// *** logic/video_sync_ctrl.sv ***
`timescale 1ns/1ps
`include "video_sync_cfg.svh"

// Overview of operation
// - Blank driven out: active period comes from programmed field start/stop values.
// - Blank as input: external blank defines active period, field values ignored.
// - Pixel data leaves the shift path only inside the active display period.
// - Master mode drives hsync, vsync and blank as outputs from own counters.
// - Slave mode takes hsync and vsync as inputs; blank input or output.
// - Slave waits for hsync fall per line and vsync fall per field.
// - Every line re-aligns on hsync, so drift stays within one pixel.
// - Works with video clock from static level up to 25 MHz.
// - Display off: sync and blank continue, default pixel out, no fetches.
// - Load-register or load-all command can set the display-on bit.
// - Load-register issued during refresh is held until the refresh completes.
// - Blanking time drives the programmed 8-bit default value on pixel pins.
// - External hsync and vsync reset horizontal and vertical counters.
// - Master with window status enabled releases sync pins during active display.
// - Horizontal and vertical timing counters are 12 bits wide.
module video_sync_ctrl import video_sync_pkg::*; #(
	parameter int ADDR_WIDTH = 8,
	parameter int PIXEL_WIDTH = 8,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset (the video clock)
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_WIDTH-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read channels
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_WIDTH-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Fetched pixel stream from memory
	input wire logic fetch_valid,
	input wire logic [PIXEL_WIDTH-1:0] fetch_data,
	output logic fetch_ready,
	output logic fetch_enable,
	// Sync and blank pins
	input wire sync_in_type sync_in,
	output sync_out_type sync_out,
	// Pixel data pins
	output logic [PIXEL_WIDTH-1:0] pixel_data_pins
);

	// ==========================================================
	// State
	typedef struct packed {
		wr_state_type wr_state;
		rd_state_type rd_state;
		logic have_aw;
		logic have_w;
		logic [ADDR_WIDTH-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		timing_type timing;
		logic [PIXEL_WIDTH-1:0] default_video;
		logic display_on;
		logic slave;
		logic blank_input;
		logic window_enable;
		logic pending;
		logic pending_value;
		logic refresh_busy;
		logic [11:0] hcount;
		logic [11:0] vcount;
		logic hsync_prev;
		logic vsync_prev;
		logic active;
		logic hsync;
		logic vsync;
		logic blank;
		logic [PIXEL_WIDTH-1:0] pixel;
	} ctrl_state_type;

	ctrl_state_type st;
	ctrl_state_type next_st;

	logic blank_in_eff;
	logic active_prog;
	logic active;
	logic h_fall;
	logic v_fall;
	logic line_end;
	logic field_end;
	logic drain;
	logic cmd_write;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [PIXEL_WIDTH-1:0] fifo_out_data;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = merge({20'h0, old}, data, strb);
		return res[11:0];
	endfunction : merge12

	function automatic logic in_range(input logic [11:0] value, input logic [11:0] lo, input logic [11:0] hi);
		return (value >= lo) && (value < hi);
	endfunction : in_range

	// ==========================================================
	// Pixel buffer between memory fetch and the shift path
	pixel_fifo #(
		.WIDTH(PIXEL_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_pixel_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_valid(fetch_valid & st.display_on),
		.s_data(fetch_data),
		.s_ready(fifo_in_ready),
		.m_valid(fifo_out_valid),
		.m_data(fifo_out_data),
		.m_ready(drain)
	);

	// ==========================================================
	// Combinational view of the raster
	assign blank_in_eff = st.slave & st.blank_input;
	assign active_prog = in_range(st.hcount, st.timing.horizontal_field_start, st.timing.horizontal_field_stop) &&
		in_range(st.vcount, st.timing.vertical_field_start, st.timing.vertical_field_stop);
	assign active = blank_in_eff ? ~sync_in.blank : active_prog;
	// Pins are synchronous, so the previous sample is a clean edge reference
	assign h_fall = st.slave & st.hsync_prev & ~sync_in.hsync;
	assign v_fall = st.slave & st.vsync_prev & ~sync_in.vsync;
	assign line_end = st.hcount == st.timing.line_len;
	assign field_end = st.slave ? v_fall : (line_end && st.vcount == st.timing.frame_len);
	assign drain = active & st.display_on & fifo_out_valid;
	assign fetch_ready = fifo_in_ready & st.display_on;
	assign fetch_enable = st.display_on;
	assign cmd_write = (st.wr_state == WR_IDLE) && st.have_aw && st.have_w && (st.waddr == `OFS_OPCODE);

	// ==========================================================
	// Bus handshakes and pins
	assign awready = (st.wr_state == WR_IDLE) && !st.have_aw;
	assign wready = (st.wr_state == WR_IDLE) && !st.have_w;
	assign bvalid = st.wr_state == WR_RESP;
	assign bresp = st.bresp;
	assign arready = st.rd_state == RD_IDLE;
	assign rvalid = st.rd_state == RD_DATA;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign pixel_data_pins = st.pixel;
	assign sync_out.hsync = st.hsync;
	assign sync_out.vsync = st.vsync;
	assign sync_out.blank = st.blank;
	// Master with window enable set releases sync pins while active so window status can share them
	assign sync_out.hsync_oe_n = st.slave | (st.window_enable & st.active);
	assign sync_out.vsync_oe_n = st.slave | (st.window_enable & st.active);
	assign sync_out.blank_oe_n = blank_in_eff;

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_st = st;

		// Write path: address and data taken in either order
		if (st.wr_state == WR_IDLE) begin
			if (awvalid && awready) begin
				next_st.have_aw = 1'b1;
				next_st.waddr = awaddr;
			end
			if (wvalid && wready) begin
				next_st.have_w = 1'b1;
				next_st.wdata = wdata;
				next_st.wstrb = wstrb;
			end
			if (st.have_aw && st.have_w) begin
				next_st.have_aw = 1'b0;
				next_st.have_w = 1'b0;
				next_st.wr_state = WR_RESP;
				next_st.bresp = `RESP_OKAY;
				unique case (st.waddr)
					`OFS_VIDEO_STATUS, `OFS_POSITION, `OFS_OPCODE: begin
					end
					`OFS_HSYNC_STOP: next_st.timing.hsync_stop = merge12(st.timing.hsync_stop, st.wdata, st.wstrb);
					`OFS_HFIELD_START: next_st.timing.horizontal_field_start =
						merge12(st.timing.horizontal_field_start, st.wdata, st.wstrb);
					`OFS_HFIELD_STOP: next_st.timing.horizontal_field_stop =
						merge12(st.timing.horizontal_field_stop, st.wdata, st.wstrb);
					`OFS_LINE_LEN: next_st.timing.line_len = merge12(st.timing.line_len, st.wdata, st.wstrb);
					`OFS_VSYNC_STOP: next_st.timing.vsync_stop = merge12(st.timing.vsync_stop, st.wdata, st.wstrb);
					`OFS_VFIELD_START: next_st.timing.vertical_field_start =
						merge12(st.timing.vertical_field_start, st.wdata, st.wstrb);
					`OFS_VFIELD_STOP: next_st.timing.vertical_field_stop =
						merge12(st.timing.vertical_field_stop, st.wdata, st.wstrb);
					`OFS_FRAME_LEN: next_st.timing.frame_len = merge12(st.timing.frame_len, st.wdata, st.wstrb);
					`OFS_DEFAULT_VIDEO: begin
						if (st.wstrb[0]) begin
							next_st.default_video = st.wdata[PIXEL_WIDTH-1:0];
						end
					end
					`OFS_CONTROL: begin
						if (st.wstrb[0]) begin
							next_st.slave = st.wdata[`BIT_SLAVE];
							next_st.blank_input = st.wdata[`BIT_BLANK_INPUT];
							next_st.window_enable = st.wdata[`BIT_WINDOW_ENABLE];
						end
					end
					default: next_st.bresp = `RESP_SLVERR;
				endcase
			end
		end else if (bready) begin
			next_st.wr_state = WR_IDLE;
		end

		// Read path: answer one cycle after the address is taken
		if (st.rd_state == RD_IDLE) begin
			if (arvalid) begin
				next_st.rd_state = RD_DATA;
				next_st.rresp = `RESP_OKAY;
				next_st.rdata = 32'h0;
				unique case (araddr)
					`OFS_VIDEO_STATUS: begin
						next_st.rdata[`BIT_DISPLAY_ON] = st.display_on;
						next_st.rdata[`BIT_ACTIVE] = st.active;
						next_st.rdata[`BIT_PENDING] = st.pending;
						next_st.rdata[`BIT_REFRESH] = st.refresh_busy;
					end
					`OFS_OPCODE: begin
					end
					`OFS_HSYNC_STOP: next_st.rdata[11:0] = st.timing.hsync_stop;
					`OFS_HFIELD_START: next_st.rdata[11:0] = st.timing.horizontal_field_start;
					`OFS_HFIELD_STOP: next_st.rdata[11:0] = st.timing.horizontal_field_stop;
					`OFS_LINE_LEN: next_st.rdata[11:0] = st.timing.line_len;
					`OFS_VSYNC_STOP: next_st.rdata[11:0] = st.timing.vsync_stop;
					`OFS_VFIELD_START: next_st.rdata[11:0] = st.timing.vertical_field_start;
					`OFS_VFIELD_STOP: next_st.rdata[11:0] = st.timing.vertical_field_stop;
					`OFS_FRAME_LEN: next_st.rdata[11:0] = st.timing.frame_len;
					`OFS_DEFAULT_VIDEO: next_st.rdata[PIXEL_WIDTH-1:0] = st.default_video;
					`OFS_POSITION: begin
						next_st.rdata[11:0] = st.hcount;
						next_st.rdata[`POS_V_LSB +: 12] = st.vcount;
					end
					`OFS_CONTROL: begin
						next_st.rdata[`BIT_SLAVE] = st.slave;
						next_st.rdata[`BIT_BLANK_INPUT] = st.blank_input;
						next_st.rdata[`BIT_WINDOW_ENABLE] = st.window_enable;
					end
					default: next_st.rresp = `RESP_SLVERR;
				endcase
			end
		end else if (rready) begin
			next_st.rd_state = RD_IDLE;
		end

		// Raster counters; every state bit holds when the clock stops
		next_st.hsync_prev = sync_in.hsync;
		next_st.vsync_prev = sync_in.vsync;
		if (st.slave) begin
			// Counters park at the line or frame length until the next falling sync
			if (h_fall) begin
				next_st.hcount = 12'h000;
				if (st.vcount != st.timing.frame_len) begin
					next_st.vcount = 12'(st.vcount + 1'b1);
				end
			end else if (!line_end) begin
				next_st.hcount = 12'(st.hcount + 1'b1);
			end
			if (v_fall) begin
				next_st.vcount = 12'h000;
			end
		end else begin
			next_st.hcount = line_end ? 12'h000 : 12'(st.hcount + 1'b1);
			if (line_end) begin
				next_st.vcount = (st.vcount == st.timing.frame_len) ? 12'h000 : 12'(st.vcount + 1'b1);
			end
		end

		// Sync and blank keep running whether or not display is on
		next_st.hsync = st.hcount >= st.timing.hsync_stop;
		next_st.vsync = st.vcount >= st.timing.vsync_stop;
		next_st.blank = ~active_prog;
		next_st.active = active;
		next_st.pixel = drain ? fifo_out_data : st.default_video;

		// Refresh spans from the first active pixel to the end of the field; a fresh active pixel wins
		next_st.refresh_busy = (st.display_on & active) | (st.refresh_busy & ~field_end);
		if (field_end && st.pending) begin
			next_st.display_on = st.pending_value;
			next_st.pending = 1'b0;
		end

		// Commands come after the field-end step, so a new one is never lost
		if (cmd_write) begin
			unique case (st.wdata[`OPCODE_MSB:`OPCODE_LSB])
				`CMD_LOAD_ALL: begin
					next_st.display_on = st.wdata[`BIT_DISPLAY_ON];
				end
				`CMD_LOAD_REGISTER: begin
					if (st.refresh_busy && !field_end) begin
						next_st.pending = 1'b1;
						next_st.pending_value = st.wdata[`BIT_DISPLAY_ON];
					end else begin
						next_st.display_on = st.wdata[`BIT_DISPLAY_ON];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.wr_state <= WR_IDLE;
			st.rd_state <= RD_IDLE;
			st.timing <= {8{`RESET_TIMING}};
			st.default_video <= `RESET_DEFAULT_VIDEO;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_BLANK_FROM_FIELD: assert property (1'b1 |=> sync_out.blank == !$past(active_prog))
		else $error("driven blank does not follow field range");
	AST_BLANK_INPUT_GATES: assert property (blank_in_eff && sync_in.blank |-> !drain)
		else $error("pixel drained while external blank high");
	AST_NO_SHIFT_OUTSIDE: assert property (!active |-> !drain)
		else $error("pixel drained outside active period");
	AST_MASTER_DRIVES: assert property (!st.slave && !st.window_enable |-> !sync_out.hsync_oe_n &&
		!sync_out.vsync_oe_n && !sync_out.blank_oe_n)
		else $error("master not driving sync pins");
	AST_SLAVE_INPUTS: assert property (st.slave |-> sync_out.hsync_oe_n && sync_out.vsync_oe_n)
		else $error("slave driving sync pins");
	AST_HSYNC_RESET: assert property (h_fall |=> st.hcount == 12'h000 ##1 st.hcount == 12'h001)
		else $error("hsync fall did not restart the line");
	AST_VSYNC_RESET: assert property (v_fall |=> st.vcount == 12'h000)
		else $error("vsync fall did not restart the field");
	AST_DISPLAY_OFF: assert property (!st.display_on |-> !fetch_ready && !fetch_enable && !drain)
		else $error("fetch while display off");
	AST_DEFAULT_IN_BLANK: assert property (!active |=> pixel_data_pins == $past(st.default_video))
		else $error("default value not driven during blanking");
	AST_DEFERRED_CMD: assert property (st.pending && field_end && !cmd_write |=>
		st.display_on == $past(st.pending_value) && !st.pending)
		else $error("held command not executed at field end");
	AST_LOAD_ALL: assert property (cmd_write && st.wdata[`OPCODE_MSB:`OPCODE_LSB] == `CMD_LOAD_ALL |=>
		st.display_on == $past(st.wdata[`BIT_DISPLAY_ON]))
		else $error("load-all did not set display-on");
	AST_RELEASE_ACTIVE: assert property (!st.slave && st.window_enable && st.active |-> sync_out.hsync_oe_n)
		else $error("sync pins not released in active period");

	COV_SLAVE_LINE: cover property (h_fall ##[1:20] drain);
	COV_DEFERRED: cover property (st.pending ##[1:1000] !st.pending);
	COV_MASTER_FIELD: cover property (!st.slave && field_end);
	COV_WRITE: cover property (bvalid && bready);

endmodule : video_sync_ctrl

// *** verif/video_source_model.sv ***
`timescale 1ns/1ps

// ==========================================
// External video source and memory fetch side
module video_source_model import video_sync_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Stall control
	input wire logic slow,
	// Pins toward the block
	output sync_in_type src,
	output logic fetch_valid,
	output logic [7:0] fetch_data,
	input wire logic fetch_ready,
	// Raster position of the source
	output logic [4:0] cyc_idx,
	output logic [2:0] line_idx
);
	logic [7:0] word;
	logic [1:0] gap;
	// Lines of 20 clocks, 8 lines a field
	assign src.hsync = cyc_idx > 5'h01;
	assign src.vsync = !(line_idx == 3'h0 && cyc_idx >= 5'h05);
	assign src.blank = !(cyc_idx >= 5'h06 && cyc_idx < 5'h0e);
	// Released data line shows the inverse so a stale word is never mistaken
	assign fetch_data = fetch_valid ? word : ~word;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_idx <= 5'h00;
			line_idx <= 3'h0;
			fetch_valid <= 1'b0;
			word <= 8'h80;
			gap <= 2'h0;
		end else begin
			cyc_idx <= (cyc_idx == 5'h13) ? 5'h00 : cyc_idx + 5'h01;
			if (cyc_idx == 5'h13)
				line_idx <= line_idx + 3'h1;
			if (fetch_valid && fetch_ready) begin
				word <= {1'b1, word[6:0] + 7'h01};
				fetch_valid <= !slow;
				gap <= slow ? 2'h3 : 2'h0;
			end else if (!fetch_valid) begin
				if (gap == 2'h0)
					fetch_valid <= 1'b1;
				else
					gap <= gap - 2'h1;
			end
		end
	end
endmodule : video_source_model

// *** verif/video_sync_master_slave_control_test.sv ***
`timescale 1ns/1ps
`include "video_sync_cfg.svh"

module video_sync_master_slave_control_test import video_sync_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, d;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, fetch_valid, fetch_ready, fetch_enable;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata;
	logic [7:0] fetch_data, pixel_data_pins;
	logic [4:0] cyc_idx;
	logic [2:0] line_idx;
	sync_in_type sync_in, src;
	sync_out_type sync_out;
	int bad_count = 0, samples_checked = 0, act, pix, rel, nrdy, i, hlo, vlo;
	logic [7:0] ofs [8] = '{`OFS_HSYNC_STOP, `OFS_HFIELD_START, `OFS_HFIELD_STOP, `OFS_LINE_LEN,
		`OFS_VSYNC_STOP, `OFS_VFIELD_START, `OFS_VFIELD_STOP, `OFS_FRAME_LEN};
	logic [11:0] val [8] = '{12'h002, 12'h004, 12'h00c, 12'h00f, 12'h001, 12'h002, 12'h007, 12'h009};

	always #50 aclk = ~aclk;
	// Shared pins resolve to whichever party drives them
	assign sync_in = {sync_out.hsync_oe_n ? src.hsync : sync_out.hsync,
		sync_out.vsync_oe_n ? src.vsync : sync_out.vsync, sync_out.blank_oe_n ? src.blank : sync_out.blank};

	video_sync_ctrl video_sync_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data), .fetch_ready(fetch_ready),
		.fetch_enable(fetch_enable), .sync_in(sync_in), .sync_out(sync_out), .pixel_data_pins(pixel_data_pins));
	video_source_model video_source_model_inst (.aclk(aclk), .aresetn(aresetn), .slow(slow), .src(src),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data), .fetch_ready(fetch_ready), .cyc_idx(cyc_idx),
		.line_idx(line_idx));

	// ==========================================
	// Bus cycles and checking
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, ha, hw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ha = !ta && awready === 1'b1;
			hw = !tw && wready === 1'b1;
			@(posedge aclk);
			if (ha) begin
				awvalid <= 1'b0;
				ta = 1'b1;
			end
			if (hw) begin
				wvalid <= 1'b0;
				tw = 1'b1;
			end
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd

	// Counts over n clocks; pixels from the source all carry bit 7
	task automatic measure(input int n);
		act = 0;
		pix = 0;
		rel = 0;
		nrdy = 0;
		hlo = 0;
		vlo = 0;
		repeat (n) begin
			@(negedge aclk);
			if (sync_out.blank === 1'b0) act++;
			if (sync_out.hsync === 1'b0) hlo++;
			if (sync_out.vsync === 1'b0) vlo++;
			if (pixel_data_pins[7] === 1'b1) pix++;
			else if (sync_out.blank === 1'b1) check("blank pixel", 32'h5a, pixel_data_pins);
			if (sync_out.hsync_oe_n === 1'b1) rel++;
			if (fetch_ready === 1'b0) nrdy++;
		end
	endtask : measure

	// ==========================================
	// Scenarios
	task automatic t_regs;
		for (int k = 0; k < 8; k++) wr(ofs[k], {20'hfffff, val[k]});
		for (int k = 0; k < 8; k++) begin
			rd(ofs[k]);
			check("timing reg", {20'h0, val[k]}, d);
			check("read resp", `RESP_OKAY, r);
		end
		wr(`OFS_DEFAULT_VIDEO, 32'h5a);
		check("write resp", `RESP_OKAY, r);
		wr(8'h3c, 32'h1);
		check("unmapped write resp", `RESP_SLVERR, r);
		rd(8'h3c);
		check("unmapped read resp", `RESP_SLVERR, r);
		check("unmapped read data", 32'h0, d);
		$display("test regs done");
	endtask : t_regs

	task automatic t_master_off;
		measure(160);
		check("active clocks", 40, act);
		check("hsync low clocks", 20, hlo);
		check("vsync low clocks", 16, vlo);
		check("fetched pixels", 0, pix);
		check("pin drive", 3'b000, {sync_out.hsync_oe_n, sync_out.vsync_oe_n, sync_out.blank_oe_n});
		check("fetch enable", 1'b0, fetch_enable);
		$display("test master off done");
	endtask : t_master_off

	task automatic t_display_on;
		wr(`OFS_OPCODE, {16'h0, `CMD_LOAD_ALL, 8'h01});
		rd(`OFS_VIDEO_STATUS);
		check("display on", 32'h1, d & 32'h1);
		repeat (160) @(posedge aclk);
		measure(160);
		check("fetched pixels", 40, pix);
		check("fifo refused", 1, nrdy > 0);
		check("fetch enable", 1'b1, fetch_enable);
		$display("test display on done");
	endtask : t_display_on

	task automatic t_deferred;
		i = 0;
		while (sync_out.blank !== 1'b0 && i < 400) begin
			@(negedge aclk);
			i++;
		end
		wr(`OFS_OPCODE, {16'h0, `CMD_LOAD_REGISTER, 8'h00});
		rd(`OFS_VIDEO_STATUS);
		check("held command", 32'h5, d & 32'h5);
		repeat (200) @(posedge aclk);
		rd(`OFS_VIDEO_STATUS);
		check("applied command", 32'h0, d & 32'h5);
		wr(`OFS_OPCODE, {16'h0, `CMD_LOAD_REGISTER, 8'h01});
		rd(`OFS_VIDEO_STATUS);
		check("direct command", 32'h1, d & 32'h5);
		$display("test deferred done");
	endtask : t_deferred

	task automatic t_window;
		wr(`OFS_CONTROL, 32'h4);
		measure(160);
		check("released clocks", 40, rel);
		$display("test window done");
	endtask : t_window

	task automatic t_slave;
		wr(`OFS_CONTROL, 32'h3);
		@(negedge aclk);
		check("pin drive", 3'b111, {sync_out.hsync_oe_n, sync_out.vsync_oe_n, sync_out.blank_oe_n});
		// First start command goes out in the source's last line, ahead of its field sync
		i = 0;
		while (line_idx != 3'h7 && i < 400) begin
			@(negedge aclk);
			i++;
		end
		wr(`OFS_OPCODE, {16'h0, `CMD_LOAD_ALL, 8'h01});
		rd(`OFS_VIDEO_STATUS);
		check("slave display on", 32'h1, d & 32'h1);
		repeat (160) @(posedge aclk);
		measure(160);
		check("fetched pixels", 64, pix);
		i = 0;
		while (!(line_idx == 3'h3 && cyc_idx == 5'h0a) && i < 400) begin
			@(negedge aclk);
			i++;
		end
		rd(`OFS_POSITION);
		check("line position", 32'h3, d[27:16]);
		check("pixel position", 1, d[11:0] >= 12'h008 && d[11:0] <= 12'h00e);
		$display("test slave done");
	endtask : t_slave

	task automatic t_slow;
		@(posedge aclk);
		slow <= 1'b1;
		repeat (160) @(posedge aclk);
		measure(160);
		check("underrun", 1, pix > 0 && pix < 64);
		$display("test slow done");
	endtask : t_slow

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_master_off;
		t_display_on;
		t_deferred;
		t_window;
		t_slave;
		t_slow;
		end_sim;
	end

	// All scenarios need about 2000 clocks
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		end_sim;
	end
endmodule : video_sync_master_slave_control_test
